// File: sdhi_pkg.sv
// Package: constants and carrier types for the SDLC host data interface
package sdhi_pkg;

  // ----------------------------------------------------------------
  // Register selects (reg_sel_hi, reg_sel_lo)
  // ----------------------------------------------------------------
  localparam logic [1:0] SDHI_SEL_CMD_STAT = 2'h0;
  localparam logic [1:0] SDHI_SEL_PARM_RES = 2'h1;
  localparam logic [1:0] SDHI_SEL_TEST_TXR = 2'h2;
  localparam logic [1:0] SDHI_SEL_RXR = 2'h3;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int SDHI_ST_CMD_BUSY = 7;
  localparam int SDHI_ST_CMD_FULL = 6;
  localparam int SDHI_ST_PARM_FULL = 5;
  localparam int SDHI_ST_RES_AVAIL = 4;
  localparam int SDHI_ST_TX_IRQ = 3;
  localparam int SDHI_ST_RX_IRQ = 2;
  localparam int SDHI_ST_TX_RES_AVAIL = 1;
  localparam int SDHI_ST_RX_RES_AVAIL = 0;

  // ----------------------------------------------------------------
  // Parameter counts, reset values, test mode bit
  // ----------------------------------------------------------------
  localparam logic [2:0] SDHI_TX_PARMS = 3'h4;
  localparam logic [2:0] SDHI_RX_PARMS = 3'h2;
  localparam int SDHI_TEST_RESET_BIT = 0;
  localparam logic [7:0] SDHI_BYTE_RESET = 8'h00;

  // Result codes placed in the result registers
  localparam logic [7:0] SDHI_RES_TX_OK = 8'h0c;
  localparam logic [7:0] SDHI_RES_RX_OK = 8'h00;
  localparam logic [7:0] SDHI_RES_RX_FCS = 8'h03;
  localparam logic [7:0] SDHI_RES_RX_OVER = 8'h05;
  localparam logic [7:0] SDHI_RES_CMD_OK = 8'h00;

  // ----------------------------------------------------------------
  // Command classes decoded from the command byte's top bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDHI_CMD_IMM,
    SDHI_CMD_TX,
    SDHI_CMD_RX_GEN,
    SDHI_CMD_RX_SEL
  } sdhi_cmd_type;

  // Host bus cycle, already synchronised
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] sel;
    logic tx_ack_n;
    logic rx_ack_n;
    logic [7:0] data;
  } sdhi_bus_type;

  // Frame engine side: a transmit frame order
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] ctrl;
    logic [15:0] len;
  } sdhi_txfrm_type;

endpackage : sdhi_pkg

// File: sdhi_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none

module sdhi_sync
  #(parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0)
  (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
  );

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // Two stages; only the second stage is read
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= INIT;
      dout <= INIT;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // sdhi_sync

`default_nettype wire

// File: sdhi_req.sv
// Data request line with acknowledge completion for one channel
`timescale 1ns/10ps
`default_nettype none

module sdhi_req
  import sdhi_pkg::*;
  (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic need,
  input wire logic done,
  // Request out
  output logic req
  );

  // ----------------------------------------------------------------
  // Request rises when a byte is needed, falls on completed transfer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      req <= 1'b0;
    else if (need)
      req <= 1'b1; // New byte outranks a finished one
    else if (done)
      req <= 1'b0;
  end

endmodule // sdhi_req

`default_nettype wire

// File: sdhi_host_if.sv
// Host port of the SDLC link controller: registers, requests, interrupts
// How it works
// - Seven registers picked by two select bits, chip select, read, write.
// - Every operation starts by a command byte write; device starts once its last parameter is written.
// - Extra command bytes arrive one by one through the parameter register.
// - Immediate commands leave completion info in the result register.
// - Transmit outcomes go to tx result, receive outcomes to rx result.
// - Status register gives command, execution and result handshakes.
// - Writing the test mode register can soft reset the controller.
// - No data register is decoded; bytes move only via acknowledges.
// - Done interrupt rises when results are due, or a data transfer in non-DMA mode.
// - Interrupt holds until results read or the transfer is done.
// - Status bits mirror each interrupt line for polled use.
// - Transmit and receive data paths are independent, DMA or not.
// - Tx request asks for a byte; tx acknowledge opens the tx path.
// - Rx request offers a byte; rx acknowledge opens the rx path.
// - Ack with write loads, ack with read returns, chip select ignored.
// - Transmit frame takes address, control, length low, length high.
// - After last parameter assert request-to-send, wait for clear-to-send.
// - Tx requests start with flag/header, repeat per byte until count.
// - Count exhausted: stop requests, send FCS and flag, raise tx done.
// - General receive takes all frames; selective matches two addresses.
// - Receive needs buffer length low and high before it goes active.
// - On closing flag check FCS, raise rx done, report good or bad.
// - Frame longer than buffer raises receive error interrupt early.
`timescale 1ns/10ps
`default_nettype none

module sdhi_host_if
  import sdhi_pkg::*;
  (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_sel_hi,
  input wire logic reg_sel_lo,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // Data channel handshakes
  output logic tx_xfer_req,
  input wire logic tx_xfer_ack_n,
  output logic rx_xfer_req,
  input wire logic rx_xfer_ack_n,
  // Interrupt lines
  output logic tx_done_irq,
  output logic rx_done_irq,
  // Channel mode: 1 selects DMA service, 0 interrupt service
  input wire logic tx_dma_mode,
  input wire logic rx_dma_mode,
  // Selective receive addresses
  input wire logic [7:0] match_addr0,
  input wire logic [7:0] match_addr1,
  // Modem handshakes
  output logic rts,
  input wire logic cts,
  // Frame transmitter side
  output var sdhi_txfrm_type tx_frame,
  output logic tx_start,
  input wire logic tx_byte_slot,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  input wire logic tx_frame_end,
  // Frame receiver side
  output logic rx_enable,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_addr_byte,
  input wire logic rx_frame_end,
  input wire logic rx_fcs_ok,
  // Immediate command completion from the rest of the unit
  input wire logic imm_done,
  input wire logic [7:0] imm_result,
  // Controller-wide software reset
  output logic soft_reset
  );

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_PARM, ST_RTS, ST_SEND, ST_TAIL} sdhi_txst_type;
  sdhi_bus_type bus_pin, bus;
  sdhi_bus_type bus_prev;
  sdhi_txst_type txst;
  logic cts_s;
  logic [7:0] cmd, result, tx_result, rx_result, parm_buf [0:3];
  logic [2:0] parm_cnt, parm_need;
  logic cmd_busy, res_avail, tx_res_avail, rx_res_avail;
  logic [15:0] tx_left, rx_len, rx_count;
  logic rx_armed, rx_sel_mode, rx_pass, rx_err_sent;
  logic [7:0] rx_hold;
  logic rx_need, tx_need, tx_have;
  logic rst_all;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign bus_pin = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n,
                     sel: {reg_sel_hi, reg_sel_lo},
                     tx_ack_n: tx_xfer_ack_n, rx_ack_n: rx_xfer_ack_n,
                     data: data_in};

  sdhi_sync #(.WIDTH($bits(sdhi_bus_type)), .INIT('1)) u_bus_sync
  (
    .clock(clock),
    .rst(rst),
    .din(bus_pin),
    .dout(bus)
  );

  sdhi_sync #(.WIDTH(1), .INIT(1'b0)) u_cts_sync
  (
    .clock(clock),
    .rst(rst),
    .din(cts),
    .dout(cts_s)
  );

  // Previous strobe state for edge detection of synchronised strobes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      bus_prev <= '1;
    else
      bus_prev <= bus;
  end

  // ----------------------------------------------------------------
  // Strobe decode: one pulse per access, on the strobe's trailing edge
  // ----------------------------------------------------------------
  wire wr_end = bus.wr_n && !bus_prev.wr_n;
  wire rd_end = bus.rd_n && !bus_prev.rd_n;
  wire rd_act = !bus.rd_n;
  wire sel_cs = !bus_prev.cs_n && bus_prev.tx_ack_n && bus_prev.rx_ack_n;
  wire w_cmd = wr_end && sel_cs && bus_prev.sel == SDHI_SEL_CMD_STAT;
  wire w_parm = wr_end && sel_cs && bus_prev.sel == SDHI_SEL_PARM_RES;
  wire w_test = wr_end && sel_cs && bus_prev.sel == SDHI_SEL_TEST_TXR;
  wire r_res = rd_end && sel_cs && bus_prev.sel == SDHI_SEL_PARM_RES;
  wire r_txr = rd_end && sel_cs && bus_prev.sel == SDHI_SEL_TEST_TXR;
  wire r_rxr = rd_end && sel_cs && bus_prev.sel == SDHI_SEL_RXR;
  // Hard-selected data paths ignore chip select and the selects
  wire tx_load = wr_end && !bus_prev.tx_ack_n;
  wire rx_take = rd_end && !bus_prev.rx_ack_n;
  wire soft_pulse = w_test && bus_prev.data[SDHI_TEST_RESET_BIT];
  wire sdhi_cmd_type cmd_class = sdhi_cmd_type'(bus_prev.data[7:6]);
  wire [7:0] status = {cmd_busy, cmd_busy && parm_cnt != parm_need,
                       1'b0, res_avail, tx_done_irq, rx_done_irq,
                       tx_res_avail, rx_res_avail};

  assign rst_all = soft_reset;

  // ----------------------------------------------------------------
  // Read data mux; data registers are not in the select decode
  // ----------------------------------------------------------------
  wire [7:0] rd_mux = !bus.rx_ack_n ? rx_hold :
                      bus.sel == SDHI_SEL_CMD_STAT ? status :
                      bus.sel == SDHI_SEL_PARM_RES ? result :
                      bus.sel == SDHI_SEL_TEST_TXR ? tx_result :
                      rx_result;
  wire rd_en = rd_act && (!bus.rx_ack_n || (!bus.cs_n && bus.tx_ack_n));

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      data_out <= SDHI_BYTE_RESET;
      data_oe <= 1'b0;
      soft_reset <= 1'b0;
    end
    else
    begin
      data_out <= rd_mux;
      data_oe <= rd_en;
      soft_reset <= soft_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Command and parameter intake
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cmd <= SDHI_BYTE_RESET;
      cmd_busy <= 1'b0;
      parm_cnt <= 3'h0;
      parm_need <= 3'h0;
      for (int i = 0; i < 4; i++)
        parm_buf[i] <= SDHI_BYTE_RESET;
      rx_sel_mode <= 1'b0;
    end
    else if (rst_all)
    begin
      cmd_busy <= 1'b0;
      parm_cnt <= 3'h0;
      parm_need <= 3'h0;
    end
    else if (w_cmd && !cmd_busy)
    begin
      cmd <= bus_prev.data;
      cmd_busy <= 1'b1;
      parm_cnt <= 3'h0;
      parm_need <= cmd_class == SDHI_CMD_TX ? SDHI_TX_PARMS :
                   cmd_class == SDHI_CMD_IMM ? 3'h0 :
                   SDHI_RX_PARMS;
      rx_sel_mode <= cmd_class == SDHI_CMD_RX_SEL;
    end
    else if (w_parm && cmd_busy && parm_cnt != parm_need)
    begin
      parm_buf[parm_cnt[1:0]] <= bus_prev.data;
      parm_cnt <= parm_cnt + 3'h1;
    end
    else if (cmd_busy && parm_cnt == parm_need)
      cmd_busy <= sdhi_cmd_type'(cmd[7:6]) == SDHI_CMD_IMM && !imm_done;
  end

  wire parms_done = cmd_busy && parm_cnt == parm_need;
  wire tx_go = parms_done && sdhi_cmd_type'(cmd[7:6]) == SDHI_CMD_TX;
  wire rx_go = parms_done && cmd[7];

  // ----------------------------------------------------------------
  // Result registers and their availability flags (set wins)
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      result <= SDHI_BYTE_RESET;
      res_avail <= 1'b0;
    end
    else if (rst_all)
      res_avail <= 1'b0;
    else if (imm_done && cmd_busy)
    begin
      result <= imm_result;
      res_avail <= 1'b1;
    end
    else if (r_res)
      res_avail <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      txst <= ST_IDLE;
      tx_left <= 16'h0000;
      rts <= 1'b0;
      tx_start <= 1'b0;
      tx_frame <= '0;
      tx_result <= SDHI_BYTE_RESET;
      tx_res_avail <= 1'b0;
    end
    else if (rst_all)
    begin
      txst <= ST_IDLE;
      rts <= 1'b0;
      tx_start <= 1'b0;
      tx_res_avail <= 1'b0;
    end
    else
    begin
      tx_start <= 1'b0;
      unique case (txst)
        ST_IDLE:
          if (tx_go)
            txst <= ST_PARM;
        ST_PARM:
        begin
          tx_frame <= '{addr: parm_buf[0], ctrl: parm_buf[1],
                        len: {parm_buf[3], parm_buf[2]}};
          tx_left <= {parm_buf[3], parm_buf[2]};
          rts <= 1'b1;
          txst <= ST_RTS;
        end
        ST_RTS:
          if (cts_s)
          begin
            tx_start <= 1'b1;
            txst <= ST_SEND;
          end
        ST_SEND:
        begin
          if (tx_load && tx_left != 16'h0000)
            tx_left <= tx_left - 16'h0001;
          if (tx_frame_end)
            txst <= ST_TAIL;
        end
        ST_TAIL:
        begin
          tx_result <= SDHI_RES_TX_OK;
          rts <= 1'b0;
          txst <= ST_IDLE;
        end
      endcase
      if (txst == ST_TAIL)
        tx_res_avail <= 1'b1;
      else if (r_txr)
        tx_res_avail <= 1'b0;
    end
  end

  // Byte handed to the transmitter; request while slot empty and count left
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tx_byte <= SDHI_BYTE_RESET;
      tx_have <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_byte <= bus_prev.data;
      tx_have <= 1'b1;
    end
    else if (tx_byte_slot || rst_all)
      tx_have <= 1'b0;
  end

  assign tx_byte_valid = tx_have;
  assign tx_need = txst == ST_SEND && !tx_have && tx_left != 16'h0000
                   && !tx_xfer_req;

  sdhi_req u_tx_req
  (
    .clock(clock),
    .rst(rst),
    .need(tx_need && !rst_all),
    .done(tx_load || rst_all),
    .req(tx_xfer_req)
  );

  // ----------------------------------------------------------------
  // Receive path: length, address filter, byte hold, results
  // ----------------------------------------------------------------
  wire rx_addr_ok = !rx_sel_mode || rx_byte_in == match_addr0
                    || rx_byte_in == match_addr1;
  wire rx_over = rx_pass && rx_byte_valid && rx_count == rx_len;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rx_armed <= 1'b0;
      rx_len <= 16'h0000;
      rx_count <= 16'h0000;
      rx_pass <= 1'b0;
      rx_hold <= SDHI_BYTE_RESET;
      rx_result <= SDHI_BYTE_RESET;
      rx_res_avail <= 1'b0;
      rx_err_sent <= 1'b0;
      rx_need <= 1'b0;
    end
    else if (rst_all)
    begin
      rx_armed <= 1'b0;
      rx_pass <= 1'b0;
      rx_res_avail <= 1'b0;
      rx_need <= 1'b0;
    end
    else
    begin
      rx_need <= 1'b0;
      if (rx_go && !rx_armed)
      begin
        rx_armed <= 1'b1;
        rx_len <= {parm_buf[1], parm_buf[0]};
      end
      if (rx_armed && rx_addr_byte && rx_byte_valid)
      begin
        rx_pass <= rx_addr_ok;
        rx_count <= 16'h0000;
        rx_err_sent <= 1'b0;
      end
      else if (rx_pass && rx_byte_valid && !rx_over)
      begin
        rx_hold <= rx_byte_in;
        rx_count <= rx_count + 16'h0001;
        rx_need <= 1'b1;
      end
      if (rx_over && !rx_err_sent)
      begin
        rx_result <= SDHI_RES_RX_OVER;
        rx_err_sent <= 1'b1;
      end
      else if (rx_pass && rx_frame_end && !rx_err_sent)
      begin
        rx_result <= rx_fcs_ok ? SDHI_RES_RX_OK : SDHI_RES_RX_FCS;
        rx_pass <= 1'b0;
        rx_armed <= 1'b0;
      end
      else if (rx_frame_end)
        rx_pass <= 1'b0;
      if ((rx_over && !rx_err_sent) || (rx_pass && rx_frame_end
          && !rx_err_sent))
        rx_res_avail <= 1'b1;
      else if (r_rxr)
        rx_res_avail <= 1'b0;
    end
  end

  assign rx_enable = rx_armed;

  sdhi_req u_rx_req
  (
    .clock(clock),
    .rst(rst),
    .need(rx_need && !rst_all),
    .done(rx_take || rst_all),
    .req(rx_xfer_req)
  );

  // ----------------------------------------------------------------
  // Interrupt lines: results pending, or data due in non-DMA mode
  // ----------------------------------------------------------------
  assign tx_done_irq = tx_res_avail || (!tx_dma_mode && tx_xfer_req);
  assign rx_done_irq = rx_res_avail || (!rx_dma_mode && rx_xfer_req);

endmodule // sdhi_host_if

`default_nettype wire

// File: sdhi_host_if_sva.sv
// Checker: timing properties of the host port
`timescale 1ns/10ps
`default_nettype none

module sdhi_host_if_sva
  (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host strobes and acknowledges
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic tx_xfer_ack_n,
  input wire logic rx_xfer_ack_n,
  // Requests, interrupts and modes
  input wire logic data_oe,
  input wire logic tx_xfer_req,
  input wire logic rx_xfer_req,
  input wire logic tx_done_irq,
  input wire logic rx_done_irq,
  input wire logic rx_dma_mode,
  // Modem and frame engine
  input wire logic rts,
  input wire logic cts,
  input wire logic tx_start,
  input wire logic tx_frame_end,
  input wire logic rx_enable,
  input wire logic rx_frame_end,
  input wire logic soft_reset
  );
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Bus answers and data requests
  // ----------------------------------------------------------------
  a_host_read_drive: assert property ($fell(rd_n) && !cs_n |-> ##[1:5] data_oe)
    else $error("host read not driven");
  a_rx_ack_drive: assert property ($fell(rx_xfer_ack_n) |-> ##[1:5] data_oe)
    else $error("receive ack read not driven");
  a_tx_req_drop: assert property ($rose(tx_xfer_ack_n) |-> ##[1:5] !tx_xfer_req)
    else $error("transmit request held after transfer");
  a_rx_req_irq: assert property (rx_xfer_req && !rx_dma_mode |-> rx_done_irq)
    else $error("receive request not on interrupt line");
  a_rx_req_active: assert property ($rose(rx_xfer_req) |-> $past(rx_enable))
    else $error("receive request while receiver idle");
  // Frame start and completion, soft reset
  a_start_after_cts: assert property ($rose(tx_start) |-> $past(rts) && $past(cts, 2))
    else $error("frame started without rts and cts");
  a_tx_done_raise: assert property (tx_frame_end |-> ##[1:3] tx_done_irq)
    else $error("no transmit done interrupt");
  a_rx_done_raise: assert property (rx_frame_end && rx_enable |-> ##[1:3] rx_done_irq)
    else $error("no receive done interrupt");
  a_soft_reset_clear: assert property ($rose(soft_reset) |=> !soft_reset ##[1:2] !(rts || tx_xfer_req || rx_xfer_req))
    else $error("soft reset left state active");
  // Main scenarios
  cover property ($rose(tx_start));
  cover property ($rose(rx_xfer_req));
  cover property ($rose(soft_reset));
endmodule // sdhi_host_if_sva
`default_nettype wire

// File: sdhi_dma_model.sv
// Partner: DMA controller serving both data request lines
`timescale 1ns/10ps
`default_nettype none

module sdhi_dma_model
  (
  // Clock
  input wire logic clock,
  // Requests and read data
  input wire logic tx_req,
  input wire logic rx_req,
  input wire logic [7:0] rdata,
  // Acknowledges, strobes, write data
  output logic tx_ack_n,
  output logic rx_ack_n,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] wdata,
  // Last byte taken from the receiver
  output logic [7:0] rx_last
  );
  logic [7:0] n_tx;
  // One transfer at a time, strobe held four cycles
  initial
  begin
    {tx_ack_n, rx_ack_n, wr_n, rd_n} = 4'hf;
    wdata = 8'hff;
    rx_last = 8'h00;
    n_tx = 8'h00;
    forever
    begin
      @(posedge clock);
      #1;
      if (tx_req === 1'b1)
      begin
        wdata = 8'ha0 + n_tx;
        tx_ack_n = 0;
        wr_n = 0;
        repeat (4) @(posedge clock);
        #1;
        tx_ack_n = 1;
        wr_n = 1;
        wdata = ~wdata; // Released bus shows no stale byte
        n_tx++;
        repeat (5) @(posedge clock);
      end
      else if (rx_req === 1'b1)
      begin
        rx_ack_n = 0;
        rd_n = 0;
        repeat (4) @(posedge clock);
        #1;
        rx_last = rdata;
        rx_ack_n = 1;
        rd_n = 1;
        repeat (5) @(posedge clock);
      end
    end
  end
endmodule // sdhi_dma_model
`default_nettype wire

// File: tb.sv
// Testbench: host port of the SDLC link controller
`timescale 1ns/10ps
`default_nettype none

module tb;
  import sdhi_pkg::*;
  typedef struct packed {logic [7:0] cmd; logic [7:0] res;} sdhi_row_type;
  sdhi_row_type rows [3] = '{'{8'h01, 8'h5a}, '{8'h22, 8'ha5}, '{8'h3f, 8'h00}};
  logic clock, rst, h_cs_n, h_rd_n, h_wr_n, cts, imm_done, rx_fcs_ok;
  logic tx_dma_mode, rx_dma_mode, tx_byte_slot, tx_frame_end;
  logic rx_byte_valid, rx_addr_byte, rx_frame_end, data_oe, rts, tx_start;
  logic [1:0] h_sel;
  logic [7:0] h_data, rx_byte_in, imm_result, match_addr0, match_addr1, st;
  logic [7:0] data_out, tx_byte, p_wdata, rx_last;
  logic tx_xfer_req, rx_xfer_req, tx_done_irq, rx_done_irq;
  logic tx_byte_valid, rx_enable, soft_reset;
  logic p_tx_ack_n, p_rx_ack_n, p_wr_n, p_rd_n;
  sdhi_txfrm_type tx_frame;
  int bad_count, n_compared, n_tx, cyc, k;

  sdhi_host_if u_dut (.clock, .rst, .cs_n(h_cs_n), .rd_n(h_rd_n & p_rd_n),
    .wr_n(h_wr_n & p_wr_n), .reg_sel_hi(h_sel[1]), .reg_sel_lo(h_sel[0]),
    .data_in(p_wr_n ? h_data : p_wdata), .data_out, .data_oe, .tx_xfer_req,
    .tx_xfer_ack_n(p_tx_ack_n), .rx_xfer_req, .rx_xfer_ack_n(p_rx_ack_n),
    .tx_done_irq, .rx_done_irq, .tx_dma_mode, .rx_dma_mode, .match_addr0,
    .match_addr1, .rts, .cts, .tx_frame, .tx_start, .tx_byte_slot, .tx_byte,
    .tx_byte_valid, .tx_frame_end, .rx_enable, .rx_byte_valid, .rx_byte_in,
    .rx_addr_byte, .rx_frame_end, .rx_fcs_ok, .imm_done, .imm_result,
    .soft_reset);
  sdhi_dma_model u_dma (.clock, .tx_req(tx_xfer_req), .rx_req(rx_xfer_req),
    .rdata(data_out), .tx_ack_n(p_tx_ack_n), .rx_ack_n(p_rx_ack_n),
    .wr_n(p_wr_n), .rd_n(p_rd_n), .wdata(p_wdata), .rx_last);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Host register cycle; read data lands in st
  task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] d);
    h_sel = s;
    h_data = d;
    h_cs_n = 0;
    h_wr_n = !w;
    h_rd_n = w;
    tick(4);
    st = data_out;
    h_wr_n = 1;
    h_rd_n = 1;
    tick(3);
    h_cs_n = 1;
    h_data = ~d;
    tick(2);
  endtask
  task automatic rx_put(input logic a, input logic [7:0] b);
    rx_addr_byte = a;
    rx_byte_in = b;
    rx_byte_valid = 1;
    tick(1);
    rx_byte_valid = 0;
    rx_addr_byte = 0;
    rx_byte_in = ~b;
    tick(16);
  endtask
  task automatic end_sim();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Clock and cycle ceiling
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  // Frame transmitter stand-in: consumes each offered byte
  always @(posedge clock)
  begin
    #1;
    if (tx_byte_valid === 1'b1 && !rst)
    begin
      chk(tx_byte, 8'ha0 + n_tx[7:0]);
      n_tx++;
      tx_byte_slot = 1;
      tick(1);
      tx_byte_slot = 0;
      tick(1);
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst, h_cs_n, h_rd_n, h_wr_n, tx_dma_mode} = 5'h1f;
    {cts, imm_done, tx_byte_slot, tx_frame_end, rx_fcs_ok} = 5'h00;
    {rx_byte_valid, rx_addr_byte, rx_frame_end, rx_dma_mode} = 4'h0;
    {h_sel, h_data, rx_byte_in, imm_result} = 26'h0;
    match_addr0 = 8'h31;
    match_addr1 = 8'h32;
    tick(10);
    rst = 0;
    chk({rts, tx_xfer_req, rx_xfer_req, tx_done_irq, rx_done_irq}, 0);
    acc(0, SDHI_SEL_CMD_STAT, 8'h00);
    chk(st, 8'h00);
    foreach (rows[i])
    begin
      acc(1, SDHI_SEL_CMD_STAT, rows[i].cmd);
      acc(0, SDHI_SEL_CMD_STAT, 8'h00);
      chk(st[SDHI_ST_CMD_BUSY], 1'b1);
      imm_result = rows[i].res;
      imm_done = 1;
      tick(1);
      imm_done = 0;
      acc(0, SDHI_SEL_CMD_STAT, 8'h00);
      chk(st[SDHI_ST_RES_AVAIL], 1'b1);
      acc(0, SDHI_SEL_PARM_RES, 8'h00);
      chk(st, rows[i].res);
    end
    // Transmit frame of two bytes, interrupt-served
    tx_dma_mode = 0;
    acc(1, SDHI_SEL_CMD_STAT, 8'h40);
    acc(1, SDHI_SEL_PARM_RES, 8'h11);
    acc(1, SDHI_SEL_PARM_RES, 8'h22);
    acc(1, SDHI_SEL_PARM_RES, 8'h02);
    chk(rts, 1'b0);
    acc(1, SDHI_SEL_PARM_RES, 8'h00);
    chk({rts, tx_start}, 2'h2);
    cts = 1;
    for (k = 0; k < 40 && tx_start !== 1'b1; k++) tick(1);
    chk({tx_start, tx_frame}, {1'b1, 8'h11, 8'h22, 16'h0002});
    tick(1);
    chk({tx_xfer_req, tx_done_irq}, 2'h3);
    for (k = 0; k < 400 && n_tx < 2; k++) tick(1);
    tick(30);
    chk({n_tx[7:0], tx_xfer_req}, {8'h02, 1'b0});
    tx_frame_end = 1;
    tick(1);
    tx_frame_end = 0;
    tick(3);
    chk(tx_done_irq, 1'b1);
    acc(0, SDHI_SEL_CMD_STAT, 8'h00);
    chk({st[SDHI_ST_TX_IRQ], st[SDHI_ST_TX_RES_AVAIL]}, 2'h3);
    acc(0, SDHI_SEL_TEST_TXR, 8'h00);
    chk(st, SDHI_RES_TX_OK);
    tick(3);
    chk(tx_done_irq, 1'b0);
    cts = 0;
    // Selective receive without DMA, bad check sequence
    acc(1, SDHI_SEL_CMD_STAT, 8'hc0);
    acc(1, SDHI_SEL_PARM_RES, 8'h04);
    chk(rx_enable, 1'b0);
    acc(1, SDHI_SEL_PARM_RES, 8'h00);
    chk(rx_enable, 1'b1);
    rx_put(1, 8'h77);
    rx_put(0, 8'h55);
    chk(rx_last, 8'h00);
    rx_put(1, 8'h32);
    rx_put(0, 8'h5c);
    chk(rx_last, 8'h5c);
    rx_frame_end = 1;
    tick(1);
    rx_frame_end = 0;
    tick(3);
    chk(rx_done_irq, 1'b1);
    acc(0, SDHI_SEL_RXR, 8'h00);
    chk(st, SDHI_RES_RX_FCS);
    // General receive by DMA overrunning a one byte buffer
    rx_dma_mode = 1;
    acc(1, SDHI_SEL_CMD_STAT, 8'h80);
    acc(1, SDHI_SEL_PARM_RES, 8'h01);
    acc(1, SDHI_SEL_PARM_RES, 8'h00);
    rx_put(1, 8'h40);
    for (k = 0; k < 3; k++) rx_put(0, 8'h60 + k[7:0]);
    chk(rx_last, 8'h60);
    chk(rx_done_irq, 1'b1);
    acc(0, SDHI_SEL_CMD_STAT, 8'h00);
    chk(st[SDHI_ST_RX_RES_AVAIL], 1'b1);
    // Soft reset through the test mode register
    acc(1, SDHI_SEL_TEST_TXR, 8'h01);
    chk({rx_enable, rx_done_irq, rx_xfer_req}, 3'h0);
    end_sim();
  end
endmodule // tb

bind sdhi_host_if sdhi_host_if_sva u_sva (.clock, .rst, .cs_n, .rd_n,
  .tx_xfer_ack_n, .rx_xfer_ack_n, .data_oe, .tx_xfer_req, .rx_xfer_req,
  .tx_done_irq, .rx_done_irq, .rx_dma_mode, .rts, .cts, .tx_start,
  .tx_frame_end, .rx_enable, .rx_frame_end, .soft_reset);
`default_nettype wire
